//--- logic/elm_pkg.sv
// Shared constants and types for the engine-to-output mapping unit
package elm_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int          NUM_ENGINES = 3;
    localparam int          NUM_LEDS    = 9;
    localparam int          MEM_WORDS   = 96;
    localparam int          ADDR_W      = 7;
    localparam int          WORD_W      = 16;
    localparam int          MAP_W       = NUM_LEDS + 1;
    localparam int          PWM_W       = 8;
    localparam int          ARG_W       = 8;

    // ************************************************************
    // Row layout: bits 0..8 drive LED drivers 1..9, bit 9 the general output
    // ************************************************************
    localparam int          ROW_GPO_BIT = 9;
    localparam logic [5:0]  SEL_NONE    = 6'h00;
    localparam logic [5:0]  SEL_LED_MAX = 6'h09;
    localparam logic [5:0]  SEL_GPO     = 6'h10;

    // ************************************************************
    // Timing: master clock and instruction slot
    // ************************************************************
    localparam longint      CLK_HZ      = 200_000_000;
    localparam longint      MASTER_HZ   = 32_768;
    localparam int          MASTER_DIV  = int'(CLK_HZ / MASTER_HZ);
    localparam int          SLOT_TICKS  = 16;
    localparam logic [4:0]  SLOT_LAST   = 5'(SLOT_TICKS - 1);

    // ************************************************************
    // Instruction codes, the carrier that brings them in, and the sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        OP_LOAD_TABLE_START      = 4'h0,
        OP_LOAD_TABLE_END        = 4'h1,
        OP_MAP_TABLE_START       = 4'h2,
        OP_SINGLE_OUTPUT_SELECT  = 4'h3,
        OP_CLEAR_MAPPING         = 4'h4,
        OP_MAP_NEXT_ROW          = 4'h5,
        OP_MAP_PREV_ROW          = 4'h6,
        OP_POINTER_NEXT_ROW      = 4'h7,
        OP_POINTER_PREV_ROW      = 4'h8,
        OP_MAP_ROW_AT_LOCATION   = 4'h9,
        OP_POINTER_TO_LOCATION   = 4'ha,
        OP_SET_PWM_IMMEDIATE     = 4'hb
    } elm_op_t;

    typedef struct packed {
        elm_op_t                 op;
        logic [1:0]              engine;
        logic [ARG_W-1:0]        arg;
    } elm_instr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_APPLY = 2'b10,
        ST_SLOT  = 2'b11
    } elm_state_t;

endpackage

//--- logic/elm_prog_mem.sv
// Program memory shared by engine programs and mapping rows
`timescale 1ns/1ps
module elm_prog_mem
    import elm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [WORD_W-1:0] wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [WORD_W-1:0] rdata_o
);

    logic [WORD_W-1:0] mem_q [MEM_WORDS];

    // Writes beyond the last word are dropped
    always_ff @(posedge clk_i) begin
        if (we_i && (waddr_i < ADDR_W'(MEM_WORDS))) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Registered read; out-of-range rows read as empty
    always_ff @(posedge clk_i) begin
        if (raddr_i < ADDR_W'(MEM_WORDS)) begin
            rdata_o <= mem_q[raddr_i];
        end else begin
            rdata_o <= '0;
        end
    end

endmodule

//--- logic/elm_map_unit.sv
// Engine-to-output mapping instruction unit
`timescale 1ns/1ps

module elm_map_unit
    import elm_pkg::*;
#(
    parameter int unsigned MASTER_DIV_P = MASTER_DIV
)
(
    input  wire logic                                clk_i,
    input  wire logic                                rst_b_i,
    input  wire logic                                instr_valid_i,
    input  wire elm_instr_t                          instr_i,
    input  wire logic                                mem_we_i,
    input  wire logic [ADDR_W-1:0]                   mem_waddr_i,
    input  wire logic [WORD_W-1:0]                   mem_wdata_i,
    output logic                                     busy_o,
    output logic                                     done_o,
    output logic [NUM_ENGINES-1:0][MAP_W-1:0]        map_o,
    output logic [NUM_LEDS-1:0][PWM_W-1:0]           led_pwm_o,
    output logic [NUM_LEDS-1:0]                      led_load_o,
    output logic                                     gpo_owned_o,
    output logic                                     gpo_level_o
);

    // ************************************************************
    // Row arithmetic
    // ************************************************************

    // Forward step wraps at the end only when the pointer sits exactly on it
    function automatic logic [ADDR_W-1:0] step_next(input logic [ADDR_W-1:0] p,
                                                    input logic [ADDR_W-1:0] s,
                                                    input logic [ADDR_W-1:0] e);
        step_next = (p == e) ? s : ADDR_W'(p + 7'h01);
    endfunction

    function automatic logic [ADDR_W-1:0] step_prev(input logic [ADDR_W-1:0] p,
                                                    input logic [ADDR_W-1:0] s,
                                                    input logic [ADDR_W-1:0] e);
        step_prev = (p == s) ? e : ADDR_W'(p - 7'h01);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    elm_state_t                              state_q;
    elm_instr_t                              cmd_q;
    logic                                    act_q;
    logic [4:0]                              slot_cnt_q;
    logic [$clog2(MASTER_DIV_P+1)-1:0]       div_q;
    logic                                    tick_q;
    logic [NUM_ENGINES-1:0][ADDR_W-1:0]      start_q;
    logic [NUM_ENGINES-1:0][ADDR_W-1:0]      end_q;
    logic [NUM_ENGINES-1:0][ADDR_W-1:0]      ptr_q;
    logic [NUM_ENGINES-1:0][MAP_W-1:0]       map_q;
    logic [ADDR_W-1:0]                       raddr_q;
    logic [WORD_W-1:0]                       rdata;

    // ************************************************************
    // Decode of the incoming instruction
    // ************************************************************
    wire logic              accept    = (state_q == ST_IDLE) && instr_valid_i;
    wire logic [1:0]        eng       = instr_i.engine;
    wire logic [ADDR_W-1:0] arg_addr  = instr_i.arg[ADDR_W-1:0];
    wire logic [ADDR_W-1:0] cur_ptr   = ptr_q[eng];
    wire logic [ADDR_W-1:0] cur_start = start_q[eng];
    wire logic [ADDR_W-1:0] cur_end   = end_q[eng];
    wire logic [ADDR_W-1:0] ptr_fwd   = step_next(cur_ptr, cur_start, cur_end);
    wire logic [ADDR_W-1:0] ptr_back  = step_prev(cur_ptr, cur_start, cur_end);
    wire logic              is_fwd    = (instr_i.op == OP_MAP_NEXT_ROW) || (instr_i.op == OP_POINTER_NEXT_ROW);
    wire logic              is_back   = (instr_i.op == OP_MAP_PREV_ROW) || (instr_i.op == OP_POINTER_PREV_ROW);
    wire logic              is_at     = (instr_i.op == OP_MAP_ROW_AT_LOCATION)
                                        || (instr_i.op == OP_POINTER_TO_LOCATION)
                                        || (instr_i.op == OP_MAP_TABLE_START);
    wire logic              is_start  = (instr_i.op == OP_LOAD_TABLE_START) || (instr_i.op == OP_MAP_TABLE_START);
    wire logic              activates = (instr_i.op == OP_MAP_TABLE_START) || (instr_i.op == OP_MAP_NEXT_ROW)
                                        || (instr_i.op == OP_MAP_PREV_ROW) || (instr_i.op == OP_MAP_ROW_AT_LOCATION);
    wire logic              moves_ptr = is_fwd || is_back || is_at;
    wire logic [ADDR_W-1:0] new_ptr   = is_fwd ? ptr_fwd : (is_back ? ptr_back : arg_addr);

    // Single select code to a one-hot row; unlisted codes connect nothing
    wire logic [5:0]        sel_code  = cmd_q.arg[5:0];
    wire logic [MAP_W-1:0]  sel_row   = (sel_code == SEL_GPO) ? MAP_W'(1) << ROW_GPO_BIT :
                                        ((sel_code != SEL_NONE) && (sel_code <= SEL_LED_MAX))
                                        ? MAP_W'(1) << (sel_code - 6'h01) : '0;
    wire logic [MAP_W-1:0]  run_map   = map_q[cmd_q.engine];
    wire logic              slot_end  = (state_q == ST_SLOT) && tick_q && (slot_cnt_q == SLOT_LAST);
    wire logic              gpo_any   = map_q[0][ROW_GPO_BIT] | map_q[1][ROW_GPO_BIT] | map_q[2][ROW_GPO_BIT];

    // ************************************************************
    // Master clock enable
    // ************************************************************

    // One-cycle tick every MASTER_DIV_P system cycles; stands in for the 32 kHz domain
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == $bits(div_q)'(MASTER_DIV_P - 1));
            div_q  <= (div_q == $bits(div_q)'(MASTER_DIV_P - 1)) ? '0 : $bits(div_q)'(div_q + 1'b1);
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************

    // Idle, row read, apply, then pad out the fixed slot before signalling done
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q    <= ST_IDLE;
            cmd_q      <= '0;
            act_q      <= 1'b0;
            slot_cnt_q <= '0;
            raddr_q    <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        cmd_q   <= instr_i;
                        act_q   <= activates;
                        raddr_q <= new_ptr;
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    state_q <= ST_APPLY;
                end
                ST_APPLY: begin
                    slot_cnt_q <= '0;
                    state_q    <= ST_SLOT;
                end
                ST_SLOT: begin
                    if (slot_end) begin
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        slot_cnt_q <= slot_cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Per-engine table registers
    // ************************************************************

    // Start, end and pointer update at acceptance; only the addressed engine moves
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_q <= '0;
            end_q   <= '0;
            ptr_q   <= '0;
        end else if (accept) begin
            if (is_start) begin
                start_q[eng] <= arg_addr;
            end
            if (instr_i.op == OP_LOAD_TABLE_END) begin
                end_q[eng] <= arg_addr;
            end
            if (moves_ptr) begin
                ptr_q[eng] <= new_ptr;
            end
        end
    end

    // Connection rows change only in the apply step; pointer-only moves leave them alone
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            map_q <= '0;
        end else if (state_q == ST_APPLY) begin
            if (act_q) begin
                map_q[cmd_q.engine] <= rdata[MAP_W-1:0];
            end else if (cmd_q.op == OP_SINGLE_OUTPUT_SELECT) begin
                map_q[cmd_q.engine] <= sel_row;
            end else if (cmd_q.op == OP_CLEAR_MAPPING) begin
                map_q[cmd_q.engine] <= '0;
            end
        end
    end

    // ************************************************************
    // Output drive
    // ************************************************************

    // Only set-PWM pushes a value; a fresh mapping waits for it, released drivers keep their own value
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_pwm_o   <= '0;
            led_load_o  <= '0;
            gpo_level_o <= 1'b0;
            gpo_owned_o <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            map_o       <= '0;
        end else begin
            led_load_o  <= '0;
            if ((state_q == ST_APPLY) && (cmd_q.op == OP_SET_PWM_IMMEDIATE)) begin
                led_load_o <= run_map[NUM_LEDS-1:0];
                for (int k = 0; k < NUM_LEDS; k++) begin
                    if (run_map[k]) begin
                        led_pwm_o[k] <= cmd_q.arg;
                    end
                end
                if (run_map[ROW_GPO_BIT]) begin
                    gpo_level_o <= (cmd_q.arg != '0);
                end
            end
            gpo_owned_o <= gpo_any;                                  // Low hands the pin back to the host
            busy_o      <= (state_q != ST_IDLE) && !slot_end;
            done_o      <= slot_end;
            map_o       <= map_q;
        end
    end

    // ************************************************************
    // Memory
    // ************************************************************
    elm_prog_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we_i),
        .waddr_i (mem_waddr_i),
        .wdata_i (mem_wdata_i),
        .raddr_i (raddr_q),
        .rdata_o (rdata)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    table_start_a: assert property (accept && is_start |=> start_q[$past(eng)] == $past(arg_addr))
        else $error("table start not recorded");
    table_end_a: assert property (accept && instr_i.op == OP_LOAD_TABLE_END |=> end_q[$past(eng)] == $past(arg_addr))
        else $error("table end not recorded");
    next_wrap_a: assert property (accept && is_fwd && cur_ptr == cur_end |=> ptr_q[$past(eng)] == $past(cur_start))
        else $error("forward step did not wrap to start");
    prev_wrap_a: assert property (accept && is_back && cur_ptr == cur_start |=> ptr_q[$past(eng)] == $past(cur_end))
        else $error("backward step did not wrap to end");
    row_active_a: assert property (accept && activates |-> ##3 map_q[$past(eng, 3)] == $past(rdata[MAP_W-1:0]))
        else $error("activated row not connected");
    ptr_only_a: assert property (accept && !activates && instr_i.op != OP_SINGLE_OUTPUT_SELECT
                                 && instr_i.op != OP_CLEAR_MAPPING |-> ##3 map_q == $past(map_q, 3))
        else $error("connection changed by a pointer-only instruction");
    select_gpo_a: assert property (state_q == ST_APPLY && cmd_q.op == OP_SINGLE_OUTPUT_SELECT && sel_code == SEL_GPO
                                   |=> map_q[$past(cmd_q.engine)] == (MAP_W'(1) << ROW_GPO_BIT))
        else $error("general output select wrong");
    clear_map_a: assert property (state_q == ST_APPLY && cmd_q.op == OP_CLEAR_MAPPING
                                  |=> map_q[$past(cmd_q.engine)] == '0)
        else $error("clear left outputs connected");
    pwm_push_a: assert property (state_q == ST_APPLY && cmd_q.op == OP_SET_PWM_IMMEDIATE
                                 |=> led_load_o == $past(run_map[NUM_LEDS-1:0]))
        else $error("set-PWM did not reach mapped drivers");
    slot_len_a: assert property (done_o |-> $past(state_q) == ST_SLOT && $past(slot_cnt_q) == SLOT_LAST
                                 && $past(tick_q))
        else $error("instruction slot length wrong");

endmodule

//--- dv/elm_engine_model.sv
// Engine-side partner: offers one instruction, waits for the slot to end
`timescale 1ns/1ps
module elm_engine_model
    import elm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       req_i,
    input  wire elm_instr_t req_instr_i,
    input  wire logic       busy_i,
    input  wire logic       done_i,
    output logic            instr_valid_o,
    output elm_instr_t      instr_o,
    output logic            fin_o,
    output int              lat_o
);
    // ************************************************************
    // Offer, hold until taken, then count cycles to the done pulse
    // ************************************************************
    logic wait_q;
    int   cnt_q;

    // Word is scrambled once released so a late sample cannot look valid
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_valid_o <= 1'b0;
            instr_o       <= '0;
            wait_q        <= 1'b0;
            cnt_q         <= 0;
            fin_o         <= 1'b0;
            lat_o         <= 0;
        end else begin
            fin_o <= 1'b0;
            if (req_i) begin
                instr_valid_o <= 1'b1;
                instr_o       <= req_instr_i;
            end else if (instr_valid_o && !busy_i) begin
                instr_valid_o <= 1'b0;
                instr_o       <= elm_instr_t'(~instr_o);
                wait_q        <= 1'b1;
                cnt_q         <= 0;
            end else if (wait_q) begin
                cnt_q <= cnt_q + 1;
                if (done_i) begin
                    wait_q <= 1'b0;
                    fin_o  <= 1'b1;
                    lat_o  <= cnt_q + 1;
                end
            end
        end
    end
endmodule

//--- dv/elm_map_unit_bench.sv
// Self-checking bench for the mapping unit with a reference model
`timescale 1ns/1ps
module elm_map_unit_bench
    import elm_pkg::*;
;
    // ************************************************************
    // Signals and reference state
    // ************************************************************
    localparam int DIV = 4;
    logic clk_i = 1'b0, rst_b_i = 1'b0, req = 1'b0, mem_we = 1'b0, fin;
    logic valid, busy, done, gpo_own, gpo_lvl;
    elm_instr_t req_instr = '0, instr;
    logic [ADDR_W-1:0] mem_addr = '0;
    logic [WORD_W-1:0] mem_data = '0;
    logic [NUM_ENGINES-1:0][MAP_W-1:0] map, rw;
    logic [NUM_LEDS-1:0][PWM_W-1:0] pwm, pw;
    logic [NUM_LEDS-1:0] load, load_acc, ld_exp;
    logic [6:0] st [NUM_ENGINES], en [NUM_ENGINES], pt [NUM_ENGINES];
    logic [WORD_W-1:0] mem [MEM_WORDS];
    logic gl;
    int lat, n_mismatch = 0, compares = 0, cyc = 0;
    logic [15:0] dir [19] = '{16'h1052, 16'h2050, 16'hb05a, 16'h5000, 16'h5000, 16'h5000, 16'h6000,
        16'h0051, 16'h7000, 16'h5000, 16'ha0df, 16'h90d0, 16'h3010, 16'hb000, 16'h3009,
        16'hb0ff, 16'h3011, 16'h4000, 16'hc000};

    // Clock at 200 MHz
    always #2.5 clk_i = ~clk_i;

    elm_map_unit #(.MASTER_DIV_P(DIV)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(valid),
        .instr_i(instr), .mem_we_i(mem_we), .mem_waddr_i(mem_addr), .mem_wdata_i(mem_data),
        .busy_o(busy), .done_o(done), .map_o(map), .led_pwm_o(pwm), .led_load_o(load),
        .gpo_owned_o(gpo_own), .gpo_level_o(gpo_lvl));
    elm_engine_model eng (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .req_instr_i(req_instr),
        .busy_i(busy), .done_i(done), .instr_valid_o(valid), .instr_o(instr), .fin_o(fin), .lat_o(lat));

    // Gather load pulses over one instruction; a single-cycle pulse is easy to miss
    always @(posedge clk_i) load_acc <= req ? '0 : (load_acc | load);

    // Hang guard, well above 400 slots of about 70 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ************************************************************
    // Reference functions and checks
    // ************************************************************
    function automatic logic [MAP_W-1:0] sel_row(input logic [5:0] c);
        if (c == SEL_GPO) return 10'h200;
        if (c != SEL_NONE && c <= SEL_LED_MAX) return 10'h001 << (c - 6'h01);
        return 10'h000;
    endfunction
    function automatic logic [6:0] nxt(input int e);
        return (pt[e] == en[e]) ? st[e] : pt[e] + 7'h01;
    endfunction
    function automatic logic [6:0] prv(input int e);
        return (pt[e] == st[e]) ? en[e] : pt[e] - 7'h01;
    endfunction

    task automatic cmp(input logic [71:0] got, input logic [71:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic model(input logic [3:0] op, input int e, input logic [7:0] a);
        ld_exp = '0;
        case (op)
            4'h0: st[e] = a[6:0];
            4'h1: en[e] = a[6:0];
            4'h2: begin
                st[e] = a[6:0];
                pt[e] = a[6:0];
                rw[e] = mem[pt[e]][MAP_W-1:0];
            end
            4'h3: rw[e] = sel_row(a[5:0]);
            4'h4: rw[e] = '0;
            4'h5, 4'h7: begin
                pt[e] = nxt(e);
                if (op == 4'h5) rw[e] = mem[pt[e]][MAP_W-1:0];
            end
            4'h6, 4'h8: begin
                pt[e] = prv(e);
                if (op == 4'h6) rw[e] = mem[pt[e]][MAP_W-1:0];
            end
            4'h9, 4'ha: begin
                pt[e] = a[6:0];
                if (op == 4'h9) rw[e] = mem[pt[e]][MAP_W-1:0];
            end
            4'hb: begin
                for (int k = 0; k < NUM_LEDS; k++) if (rw[e][k]) {pw[k], ld_exp[k]} = {a, 1'b1};
                if (rw[e][ROW_GPO_BIT]) gl = (a != 8'h00);
            end
            default: ;
        endcase
    endtask

    task automatic run(input logic [3:0] op, input int e, input logic [7:0] a);
        int k;
        @(posedge clk_i);
        req <= 1'b1;
        req_instr <= '{elm_op_t'(op), 2'(e), a};
        @(posedge clk_i);
        req <= 1'b0;
        k = 0;
        while (fin !== 1'b1 && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        // A slot that never ends must fail here, not slip through on a stale latency
        cmp(72'(fin), 72'(1), "done");
        model(op, e, a);
        @(negedge clk_i);
        cmp(72'(map), 72'(rw), "map");
        cmp(72'(pwm), 72'(pw), "pwm");
        cmp(72'(load_acc), 72'(ld_exp), "load");
        cmp(72'({gpo_own, gpo_lvl}), 72'({rw[0][9] | rw[1][9] | rw[2][9], gl}), "gpo");
        // Sixteen ticks plus read, apply and handshake; one tick of phase slack, so 15 or 17 ticks fail
        cmp(72'(lat >= 16 * DIV && lat < 17 * DIV), 72'(1), "slot");
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [3:0] op;
        logic [7:0] a;
        int e;
        void'($urandom(32'h5ce83844));
        {rw, pw, gl} = '0;
        for (int i = 0; i < NUM_ENGINES; i++) {st[i], en[i], pt[i]} = '0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        cmp(72'({map, gpo_own, gpo_lvl, busy, done}), 72'(0), "reset");
        for (int i = 0; i < MEM_WORDS; i++) begin
            @(posedge clk_i);
            mem[i] = 16'($urandom());
            {mem_we, mem_addr, mem_data} <= {1'b1, 7'(i), mem[i]};
        end
        @(posedge clk_i);
        mem_we <= 1'b0;
        $display("test reset_and_fill done at %0t", $time);
        foreach (dir[i]) run(dir[i][15:12], 0, dir[i][7:0]);
        $display("test directed done at %0t", $time);
        for (int i = 0; i < 400; i++) begin
            op = 4'($urandom());
            e = $urandom() % NUM_ENGINES;
            a = (op == 4'h3) ? 8'($urandom() % 20) : (op == 4'hb) ? 8'($urandom()) : {1'($urandom()), 7'($urandom() % 96)};
            // Keep the pointer inside memory, as a sane program does
            if (((op == 4'h5 || op == 4'h7) && nxt(e) > 7'd95) || ((op == 4'h6 || op == 4'h8) && prv(e) > 7'd95)) op = 4'h9;
            run(op, e, a);
        end
        $display("test random done at %0t", $time);
        summarize();
    end
endmodule
